// *** hw/fcbu_eval_if.sv ***
// Carrier between the branch sequencer and the condition and target evaluator
`timescale 1ns/1ps
interface fcbu_eval_if
    import fcbu_pkg::*;
#(
    parameter int unsigned PC_W  = FCBU_PC_W_DEF,
    parameter int unsigned OFS_W = FCBU_OFS_W_DEF
);
    fcbu_kind_e        kind;
    logic              flag_h;
    logic              flag_t;
    logic              flag_v;
    logic              flag_i;
    logic [PC_W-1:0]   pc;
    logic [OFS_W-1:0]  offset;
    logic              cond_true;
    logic [PC_W-1:0]   pc_seq;
    logic [PC_W-1:0]   pc_target;

    modport seq (
        output kind, flag_h, flag_t, flag_v, flag_i, pc, offset,
        input  cond_true, pc_seq, pc_target
    );
    modport eval (
        input  kind, flag_h, flag_t, flag_v, flag_i, pc, offset,
        output cond_true, pc_seq, pc_target
    );
endinterface

// *** hw/fcbu_pkg.sv ***
// Shared constants and types for the flag conditional branch unit
package fcbu_pkg;

    localparam int unsigned FCBU_PC_W_DEF  = 16;
    localparam int unsigned FCBU_OFS_W_DEF = 7;
    localparam int unsigned FCBU_PC_STEP   = 1;
    localparam int unsigned FCBU_CYC_SKIP  = 1;
    localparam int unsigned FCBU_CYC_TAKEN = 2;

    typedef enum logic [2:0] {
        FCBU_HALF_CARRY_SET   = 3'h0,
        FCBU_HALF_CARRY_CLEAR = 3'h1,
        FCBU_TRANSFER_SET     = 3'h2,
        FCBU_TRANSFER_CLEAR   = 3'h3,
        FCBU_OVERFLOW_SET     = 3'h4,
        FCBU_OVERFLOW_CLEAR   = 3'h5,
        FCBU_IRQ_ENABLED      = 3'h6,
        FCBU_IRQ_DISABLED     = 3'h7
    } fcbu_kind_e;

    typedef enum logic [0:0] {
        FCBU_ST_IDLE   = 1'h0,
        FCBU_ST_SECOND = 1'h1
    } fcbu_state_e;

    localparam logic FCBU_RST_BUSY  = 1'h0;
    localparam logic FCBU_RST_DONE  = 1'h0;
    localparam logic FCBU_RST_TAKEN = 1'h0;
    localparam int unsigned FCBU_RST_PC = 32'h00000000;

endpackage

// *** hw/fcbu_target_eval.sv ***
// Flag condition test and next program counter arithmetic
`timescale 1ns/1ps
module fcbu_target_eval
    import fcbu_pkg::*;
#(
    parameter int unsigned PC_W  = FCBU_PC_W_DEF,
    parameter int unsigned OFS_W = FCBU_OFS_W_DEF
)(
    fcbu_eval_if.eval ev
);
    logic [PC_W-1:0] ofs_ext;
    logic [PC_W-1:0] step;

    assign step = PC_W'(FCBU_PC_STEP);

    // Sign extension of the word offset
    assign ofs_ext = {{(PC_W-OFS_W){ev.offset[OFS_W-1]}}, ev.offset}; // RULE_09

    assign ev.pc_seq    = ev.pc + step;
    assign ev.pc_target = ev.pc + ofs_ext + step;

    always_comb begin
        case (ev.kind)
            FCBU_HALF_CARRY_SET:   ev.cond_true = ev.flag_h;   // RULE_01
            FCBU_HALF_CARRY_CLEAR: ev.cond_true = !ev.flag_h;  // RULE_02
            FCBU_TRANSFER_SET:     ev.cond_true = ev.flag_t;   // RULE_03
            FCBU_TRANSFER_CLEAR:   ev.cond_true = !ev.flag_t;  // RULE_04
            FCBU_OVERFLOW_SET:     ev.cond_true = ev.flag_v;   // RULE_05
            FCBU_OVERFLOW_CLEAR:   ev.cond_true = !ev.flag_v;  // RULE_06
            FCBU_IRQ_ENABLED:      ev.cond_true = ev.flag_i;   // RULE_07
            FCBU_IRQ_DISABLED:     ev.cond_true = !ev.flag_i;  // RULE_08
            default:               ev.cond_true = 1'b0;
        endcase
    end
endmodule

// *** hw/fcbu_top.sv ***
// Flag conditional relative branch unit of the processor core
// Summary of operation
// RULE_01: Half carry set: new PC is PC plus offset plus one, else PC plus one.
// RULE_02: Half carry clear: new PC is PC plus offset plus one.
// RULE_03: Transfer bit set: branch to PC plus offset plus one.
// RULE_04: Transfer bit clear: branch to PC plus offset plus one.
// RULE_05: Overflow set: branch relative by offset plus one; flags untouched.
// RULE_06: Overflow clear: branch relative by offset plus one; flags untouched.
// RULE_07: Interrupts enabled: branch; one cycle when skipped, two when taken.
// RULE_08: Interrupts disabled: branch to PC plus offset plus one.
// RULE_09: Offset is signed two's complement, sign-extended before the add.
`timescale 1ns/1ps
module fcbu_top
    import fcbu_pkg::*;
#(
    parameter int unsigned PC_W  = FCBU_PC_W_DEF,
    parameter int unsigned OFS_W = FCBU_OFS_W_DEF
)(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             issue,
    input  wire logic [2:0]       kind,
    input  wire logic [OFS_W-1:0] offset,
    input  wire logic [PC_W-1:0]  pc,
    input  wire logic             flag_h,
    input  wire logic             flag_t,
    input  wire logic             flag_v,
    input  wire logic             flag_i,
    output logic                  busy_q,
    output logic                  done_q,
    output logic                  taken_q,
    output logic [PC_W-1:0]       next_pc_q
);
    if (OFS_W < 2 || OFS_W >= PC_W) begin : g_bad_width
        $error("fcbu_top: OFS_W must be at least 2 and below PC_W");
    end
    if ($bits(fcbu_kind_e) != 3) begin : g_bad_kind
        $error("fcbu_top: branch kind code must be three bits wide");
    end
    if (FCBU_PC_STEP != 1) begin : g_bad_step
        $error("fcbu_top: fall-through step must be one word");
    end
    if (FCBU_CYC_SKIP != 1 || FCBU_CYC_TAKEN != 2) begin : g_bad_timing
        $error("fcbu_top: sequencer serves one-cycle skips and two-cycle branches only");
    end

    fcbu_eval_if #(.PC_W(PC_W), .OFS_W(OFS_W)) ev ();

    fcbu_target_eval #(
        .PC_W  (PC_W),
        .OFS_W (OFS_W)
    ) u_eval (
        .ev (ev.eval)
    );

    fcbu_state_e      state_q;
    fcbu_state_e      state_d;
    logic             busy_d;
    logic             done_d;
    logic             taken_d;
    logic [PC_W-1:0]  target_q;
    logic [PC_W-1:0]  target_d;
    logic [PC_W-1:0]  next_pc_d;
    logic             accept;
    logic             skip_now;
    logic             take_now;
    logic             finish_now;

    // Operands reach the evaluator unregistered; results are used on accept
    assign ev.kind   = fcbu_kind_e'(kind);
    assign ev.flag_h = flag_h;
    assign ev.flag_t = flag_t;
    assign ev.flag_v = flag_v;
    assign ev.flag_i = flag_i;
    assign ev.pc     = pc;
    assign ev.offset = offset;

    // Requests during the second cycle of a taken branch are ignored
    assign accept     = issue && (state_q == FCBU_ST_IDLE);
    assign skip_now   = accept && !ev.cond_true;
    assign take_now   = accept && ev.cond_true;
    assign finish_now = (state_q == FCBU_ST_SECOND);

    always_comb begin
        state_d = state_q;
        case (state_q)
            FCBU_ST_IDLE: begin
                if (take_now) begin
                    state_d = FCBU_ST_SECOND; // RULE_07
                end
            end
            FCBU_ST_SECOND: begin
                state_d = FCBU_ST_IDLE;
            end
            default: begin
                state_d = FCBU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= FCBU_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Busy marks the extra cycle in which requests are refused
    always_comb begin
        busy_d = 1'b0;
        case (state_q)
            FCBU_ST_IDLE: begin
                busy_d = take_now; // RULE_07
            end
            FCBU_ST_SECOND: begin
                busy_d = 1'b0;
            end
            default: begin
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy_q <= FCBU_RST_BUSY;
        end else begin
            busy_q <= busy_d;
        end
    end

    // Target captured at issue so later input changes cannot disturb it
    always_comb begin
        target_d = target_q;
        case (state_q)
            FCBU_ST_IDLE: begin
                if (accept) begin
                    target_d = ev.pc_target; // RULE_09
                end
            end
            FCBU_ST_SECOND: begin
                target_d = target_q;
            end
            default: begin
                target_d = target_q;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            target_q <= PC_W'(FCBU_RST_PC);
        end else begin
            target_q <= target_d;
        end
    end

    // Skip finishes after one cycle, taken branch after two
    always_comb begin
        done_d = 1'b0;
        case (state_q)
            FCBU_ST_IDLE: begin
                done_d = skip_now; // RULE_07
            end
            FCBU_ST_SECOND: begin
                done_d = 1'b1; // RULE_07
            end
            default: begin
                done_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done_q <= FCBU_RST_DONE;
        end else begin
            done_q <= done_d;
        end
    end

    // Taken qualifies only the completion of a branch that was followed
    always_comb begin
        taken_d = 1'b0;
        case (state_q)
            FCBU_ST_IDLE: begin
                taken_d = 1'b0;
            end
            FCBU_ST_SECOND: begin
                taken_d = 1'b1; // RULE_07
            end
            default: begin
                taken_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            taken_q <= FCBU_RST_TAKEN;
        end else begin
            taken_q <= taken_d;
        end
    end

    // No status flag is an output: this unit leaves flags untouched
    always_comb begin
        next_pc_d = next_pc_q;
        case (state_q)
            FCBU_ST_IDLE: begin
                if (skip_now) begin
                    next_pc_d = ev.pc_seq; // RULE_01
                end
            end
            FCBU_ST_SECOND: begin
                next_pc_d = target_q; // RULE_05
            end
            default: begin
                next_pc_d = next_pc_q;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            next_pc_q <= PC_W'(FCBU_RST_PC);
        end else begin
            next_pc_q <= next_pc_d;
        end
    end
endmodule

// *** test/fcbu_top_sva.sv ***
// Assertion checker for the flag conditional branch unit
`timescale 1ns/1ps
module fcbu_top_sva
    import fcbu_pkg::*;
#(
    parameter int unsigned PC_W  = FCBU_PC_W_DEF,
    parameter int unsigned OFS_W = FCBU_OFS_W_DEF
)(
    input wire logic             mclk,
    input wire logic             sys_rst,
    input wire logic             issue,
    input wire logic [2:0]       kind,
    input wire logic [OFS_W-1:0] offset,
    input wire logic [PC_W-1:0]  pc,
    input wire logic             flag_h,
    input wire logic             flag_t,
    input wire logic             flag_v,
    input wire logic             flag_i,
    input wire logic             busy_q,
    input wire logic             done_q,
    input wire logic             taken_q,
    input wire logic [PC_W-1:0]  next_pc_q
);
    logic            acc;
    logic            cnd;
    logic [3:0]      flg;
    logic [PC_W-1:0] s_q;
    logic [PC_W-1:0] t_q;
    assign flg = {flag_i, flag_v, flag_t, flag_h};
    assign acc = issue && !busy_q;
    assign cnd = flg[kind[2:1]] ^ kind[0];
    // Expected targets latched at acceptance
    always_ff @(posedge mclk) begin
        if (acc) begin
            s_q <= pc + 1'b1;
            t_q <= pc + PC_W'(signed'(offset)) + 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_skip_one_cycle: assert property (acc && !cnd |=> done_q && !taken_q && !busy_q && next_pc_q == s_q)
        else $error("skip result wrong");
    chk_taken_busy: assert property (acc && cnd |=> busy_q && !done_q)
        else $error("taken branch not busy");
    chk_taken_two_cycles: assert property (acc && cnd |=> ##1 done_q && taken_q)
        else $error("taken branch not done in two cycles");
    chk_target_value: assert property (acc && cnd |-> ##2 next_pc_q == t_q)
        else $error("branch target wrong");
    chk_taken_with_done: assert property (taken_q |-> done_q && $past(busy_q))
        else $error("taken without done");
    chk_busy_single: assert property (busy_q |=> !busy_q && done_q)
        else $error("busy not one cycle");
    chk_pc_hold: assert property (!done_q |-> $stable(next_pc_q))
        else $error("next pc changed without done");
    chk_done_cause: assert property (done_q |-> $past(acc && !cnd) || $past(busy_q))
        else $error("done without request");
endmodule
bind fcbu_top fcbu_top_sva #(.PC_W(PC_W), .OFS_W(OFS_W)) u_sva (.mclk(mclk), .sys_rst(sys_rst), .issue(issue),
    .kind(kind), .offset(offset), .pc(pc), .flag_h(flag_h), .flag_t(flag_t), .flag_v(flag_v), .flag_i(flag_i),
    .busy_q(busy_q), .done_q(done_q), .taken_q(taken_q), .next_pc_q(next_pc_q));

// *** test/fcbu_top_test.sv ***
// Self-checking bench for the flag conditional branch unit
`timescale 1ns/1ps
module fcbu_top_test;
    import fcbu_pkg::*;
    logic        mclk = 0, sys_rst = 1, issue = 0, flag_h = 0, flag_t = 0, flag_v = 0, flag_i = 0;
    logic [2:0]  kind = 0;
    logic [6:0]  offset = 0;
    logic [15:0] pc = 0, next_pc_q;
    logic        busy_q, done_q, taken_q;
    logic [31:0] rs = 32'h55582058;
    logic [16:0] exq[$];
    int          errors = 0, check_count = 0, cyc = 0;
    fcbu_top dut (.mclk(mclk), .sys_rst(sys_rst), .issue(issue), .kind(kind), .offset(offset), .pc(pc),
        .flag_h(flag_h), .flag_t(flag_t), .flag_v(flag_v), .flag_i(flag_i), .busy_q(busy_q),
        .done_q(done_q), .taken_q(taken_q), .next_pc_q(next_pc_q));
    always #4 mclk = ~mclk;
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(logic [16:0] got, logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One branch request; r keeps issue up while busy with a changed pc
    task automatic br(logic [2:0] k, logic [6:0] o, logic [15:0] p, logic [3:0] f, logic r);
        logic c;
        c = f[k[2:1]] ^ k[0];
        @(posedge mclk);
        issue <= 1'b1;
        kind <= k;
        offset <= o;
        pc <= p;
        {flag_i, flag_v, flag_t, flag_h} <= f;
        exq.push_back(c ? {1'b1, p + {{9{o[6]}}, o} + 16'h0001} : {1'b0, p + 16'h0001});
        if (c) begin
            @(posedge mclk);
            if (r) pc <= ~p;
            else issue <= 1'b0;
        end
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 2000) begin
            errors++;
            end_sim();
        end else if (!sys_rst && done_q === 1'b1) begin
            if (exq.size() == 0) chk(17'(exq.size()), 17'h00001);
            else chk({taken_q, next_pc_q}, exq.pop_front());
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        br(3'h0, 7'h40, 16'h0000, 4'hF, 1'b0);
        br(3'h7, 7'h3F, 16'hFFFF, 4'h0, 1'b1);
        for (int i = 0; i < 300; i++) begin
            rs = xs(rs);
            br(rs[2:0], rs[9:3], rs[25:10], rs[29:26], rs[30]);
        end
        @(posedge mclk);
        issue <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(17'(exq.size()), 17'h00000);
        // Reset during the busy cycle drops the branch
        br(3'h2, 7'h05, 16'h1234, 4'h2, 1'b0);
        sys_rst <= 1'b1;
        exq.delete();
        repeat (2) @(posedge mclk);
        chk({taken_q, next_pc_q}, 17'h00000);
        chk({15'h0000, busy_q, done_q}, 17'h00000);
        sys_rst <= 1'b0;
        br(3'h3, 7'h7E, 16'h0100, 4'h0, 1'b0);
        repeat (4) @(posedge mclk);
        chk(17'(exq.size()), 17'h00000);
        end_sim();
    end
endmodule
